// File: ees_consts.svh
// Purpose: Constants for the serial memory slave front end
// Assumes: Included by its bare name
// Notes: Times are in their own unit; cycle counts derive in the module
`ifndef EES_CONSTS_SVH
`define EES_CONSTS_SVH
`define EES_DEV_TYPE 4'ha
`define EES_GRW_STD_NS 100
`define EES_GRW_FAST_NS 50
`define EES_NVP_STD_MS 10
`define EES_NVP_LV_MS 15
`define EES_SYS_NS 50
`define EES_LINK_PS 12000
`define EES_BYTE_BITS 4'h8
`define EES_ACK_BIT 4'h9
`define EES_PAGE_BYTES 16
`define EES_MEM_BYTES 2048
`define EES_TOP_BIT 3'h7
`define EES_SEG_WP_BIT 2
`endif

// File: ees_pkg.sv
// Purpose: Types for the serial memory slave front end
// Assumes: Nothing
// Notes: Constants live in ees_consts.svh
package ees_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_WORD,
      ST_DATA,
      ST_READ,
      ST_SKIP
   } ees_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } ees_lines_s;
endpackage

// File: ees_frontend.sv
// Purpose: Two-wire slave front end of a 2048-byte nonvolatile memory
// Assumes: Bus lines arrive unsynchronised; link logic on clk_link_in
// Notes: Program timer runs on clk_sys_in
//
// What this block does
// RL1: A start is SDA falling while SCL is high; commands follow it.
// RL2: Bus activity is ignored until a valid start is seen.
// RL3: A stop is SDA rising while SCL is high; it ends traffic.
// RL4: A stop returns the device to standby.
// RL5: SDA changes only while SCL is low.
// RL6: SDA edges while SCL is high are start or stop, never data.
// RL7: The master starts every transfer and makes SCL both ways.
// RL8: After a write stop, a timed program cycle runs; address ignored.
// RL9: During programming the bus logic is off and SDA released.
// RL10: With protect high, upper-half programming is suppressed; reads work.
// RL11: With protect low, the whole array reads and programs.
// RL12: Protected write: address bytes acked, data byte not acked.
// RL13: Pulses under 100 ns, or 50 ns fast, are ignored.
// RL14: A page is 16 consecutive bytes writable in one operation.
// RL15: Segments hold 16 pages of 16 bytes each.
// RL16: The segment comes from bits in the slave address byte.
// RL17: Master sends type, segment, read/write bit, then byte address.
// RL18: Start, stop, and receiver acks; a protected data byte and the last read byte go unacked.
// RL19: The device only pulls SDA low or releases it.
// RL20: Every word is eight bits wide.
// RL21: Transmitter releases after eight bits; receiver acks on ninth.
// RL22: Last slave address bit: one reads, zero writes.
// RL23: Each page-write byte advances the address counter.
// RL24: Past sixteen bytes the address wraps within the page.
// RL25: Segments with top select bit set form the protected half.
`timescale 1ns/1ps
`include "ees_consts.svh"

module ees_frontend #(
   parameter int LINK_PERIOD_PS = `EES_LINK_PS,
   parameter int FILT_W = 4,
   parameter int LOW_VOLTAGE = 0,
   parameter int PROG_CYCLES = ((LOW_VOLTAGE != 0 ? `EES_NVP_LV_MS :
      `EES_NVP_STD_MS) * 1000000) / `EES_SYS_NS,
   parameter int PROG_W = 20
) (
   input wire logic clk_sys_in,
   input wire logic clk_link_in,
   input wire logic rst_n_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic wp_in,
   input wire logic fast_mode_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic standby_out,
   output logic prog_busy_out
);
   localparam int FILT_STD = (`EES_GRW_STD_NS * 1000) / LINK_PERIOD_PS + 1;
   localparam int FILT_FAST = (`EES_GRW_FAST_NS * 1000) / LINK_PERIOD_PS + 1;

   if (FILT_STD >= 2 ** FILT_W || FILT_FAST < 1 || PROG_CYCLES < 8 ||
      PROG_CYCLES >= 2 ** PROG_W)
   begin : g_chk
      $error("ees_frontend: parameters out of range");
   end

   // ------------------------------------------------------------
   // Link reset and input synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_link_q;
   logic rst_n_link;
   logic [3:0] sy1;
   logic [3:0] sy2;
   logic wp_s;
   logic fast_s;

   always_ff @(posedge clk_link_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_link_q <= 2'h0;
         sy1 <= 4'hf;
         sy2 <= 4'hf;
      end
      else
      begin
         rst_link_q <= {rst_link_q[0], 1'b1};
         sy1 <= {scl_in, sda_in, wp_in, fast_mode_in};
         sy2 <= sy1;
      end
   end

   assign rst_n_link = rst_link_q[1];
   assign wp_s = sy2[1];
   assign fast_s = sy2[0];

   // ------------------------------------------------------------
   // Glitch filter and condition detect
   // ------------------------------------------------------------
   ees_pkg::ees_lines_s raw;
   ees_pkg::ees_lines_s filt;
   ees_pkg::ees_lines_s next_filt;
   ees_pkg::ees_lines_s prv;
   logic [1:0][FILT_W-1:0] fcnt;
   logic [1:0][FILT_W-1:0] next_fcnt;
   logic [FILT_W-1:0] lim;
   logic start;
   logic stop;
   logic rise;
   logic fall;

   assign raw = ees_pkg::ees_lines_s'(sy2[3:2]);

   always_comb
   begin
      lim = fast_s ? FILT_W'(FILT_FAST) : FILT_W'(FILT_STD);
      next_filt = filt;
      next_fcnt = fcnt;
      for (int i = 0; i < 2; i++)
      begin
         if (raw[i] == filt[i])
            next_fcnt[i] = '0; // RL13
         else if (fcnt[i] + FILT_W'(1) >= lim)
         begin
            next_filt[i] = raw[i]; // RL13
            next_fcnt[i] = '0;
         end
         else
            next_fcnt[i] = fcnt[i] + FILT_W'(1);
      end
   end

   always_ff @(posedge clk_link_in or negedge rst_n_link)
   begin
      if (!rst_n_link)
      begin
         filt <= 2'h3;
         prv <= 2'h3;
         fcnt <= '0;
      end
      else
      begin
         filt <= next_filt;
         prv <= filt;
         fcnt <= next_fcnt;
      end
   end

   assign start = filt.scl & prv.scl & prv.sda & ~filt.sda; // RL1
   assign stop = filt.scl & prv.scl & ~prv.sda & filt.sda; // RL3
   assign rise = filt.scl & ~prv.scl;
   assign fall = ~filt.scl & prv.scl;

   // ------------------------------------------------------------
   // Protocol engine and array
   // ------------------------------------------------------------
   logic [7:0] mem [0:`EES_MEM_BYTES-1]; // RL15 RL20
   ees_pkg::ees_state_e st;
   ees_pkg::ees_state_e next_st;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] txb;
   logic [7:0] next_txb;
   logic [2:0] seg;
   logic [2:0] next_seg;
   logic [10:0] addr;
   logic [10:0] next_addr;
   logic [15:0][7:0] pbuf;
   logic [15:0][7:0] next_pbuf;
   logic [15:0] pval;
   logic [15:0] next_pval;
   logic [6:0] pbase;
   logic [6:0] next_pbase;
   logic rw;
   logic next_rw;
   logic mnak;
   logic next_mnak;
   logic next_oe;
   logic wait_busy;
   logic next_wait;
   logic req_tgl;
   logic next_tgl;
   logic commit;
   logic bs1;
   logic bs2;
   logic link_busy;
   logic [7:0] rd;

   assign link_busy = wait_busy | bs2;

   always_comb
   begin
      rd = mem[addr];
      next_st = st;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_txb = txb;
      next_seg = seg;
      next_addr = addr;
      next_pbuf = pbuf;
      next_pval = pval;
      next_pbase = pbase;
      next_rw = rw;
      next_mnak = mnak;
      next_oe = sda_oe_out;
      next_wait = wait_busy & ~bs2;
      next_tgl = req_tgl;
      commit = 1'b0;
      if (stop)
      begin
         next_st = ees_pkg::ST_IDLE; // RL3 RL4
         next_oe = 1'b0;
         next_pval = '0;
         if (st == ees_pkg::ST_DATA && |pval &&
            !(wp_s && pbase[6]))
         begin
            commit = 1'b1; // RL8 RL10 RL11
            next_wait = 1'b1;
            next_tgl = ~req_tgl;
         end
      end
      else if (start)
      begin
         next_oe = 1'b0;
         next_bitcnt = 4'h0;
         next_pval = '0;
         next_st = link_busy ? ees_pkg::ST_IDLE : ees_pkg::ST_DEV; // RL2 RL9
      end
      else if (st != ees_pkg::ST_IDLE)
      begin
         if (rise)
         begin
            if (bitcnt < `EES_BYTE_BITS)
               next_shreg = {shreg[6:0], filt.sda}; // RL6
            if (bitcnt == `EES_BYTE_BITS)
               next_mnak = filt.sda; // RL21
            next_bitcnt = bitcnt + 4'h1;
         end
         else if (fall)
         begin
            if (bitcnt == `EES_BYTE_BITS)
            begin
               next_oe = 1'b0; // RL21
               case (st)
                  ees_pkg::ST_DEV:
                     if (shreg[7:4] == `EES_DEV_TYPE && !link_busy)
                     begin
                        next_oe = 1'b1; // RL17 RL18
                        next_seg = shreg[3:1]; // RL16
                        next_rw = shreg[0]; // RL22
                     end
                     else
                        next_st = ees_pkg::ST_SKIP;
                  ees_pkg::ST_WORD:
                  begin
                     next_oe = 1'b1; // RL12
                     next_addr = {seg, shreg};
                     next_pbase = {seg, shreg[7:4]};
                  end
                  ees_pkg::ST_DATA:
                     if (wp_s && addr[`EES_SEG_WP_BIT + 8])
                     begin
                        next_st = ees_pkg::ST_SKIP; // RL12 RL25
                        next_pval = '0;
                     end
                     else
                     begin
                        next_oe = 1'b1; // RL18
                        next_pbuf[addr[3:0]] = shreg; // RL14
                        next_pval[addr[3:0]] = 1'b1;
                        next_addr[3:0] = addr[3:0] + 4'h1; // RL23 RL24
                     end
                  default:
                     next_oe = 1'b0;
               endcase
            end
            else if (bitcnt == `EES_ACK_BIT)
            begin
               next_bitcnt = 4'h0;
               next_oe = 1'b0;
               case (st)
                  ees_pkg::ST_DEV:
                     if (rw)
                     begin
                        next_st = ees_pkg::ST_READ; // RL22
                        next_txb = rd;
                        next_oe = ~rd[7]; // RL19
                        next_addr = addr + 11'h1;
                     end
                     else
                        next_st = ees_pkg::ST_WORD;
                  ees_pkg::ST_WORD:
                     next_st = ees_pkg::ST_DATA;
                  ees_pkg::ST_READ:
                     if (!mnak)
                     begin
                        next_txb = rd;
                        next_oe = ~rd[7];
                        next_addr = addr + 11'h1;
                     end
                     else
                        next_st = ees_pkg::ST_SKIP;
                  default:
                     next_st = st;
               endcase
            end
            else if (st == ees_pkg::ST_READ)
               next_oe = ~txb[`EES_TOP_BIT - bitcnt[2:0]]; // RL5 RL19
         end
      end
   end

   always_ff @(posedge clk_link_in or negedge rst_n_link)
   begin
      if (!rst_n_link)
      begin
         st <= ees_pkg::ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         txb <= 8'h00;
         seg <= 3'h0;
         addr <= 11'h000;
         pbuf <= '0;
         pval <= 16'h0000;
         pbase <= 7'h00;
         rw <= 1'b0;
         mnak <= 1'b1;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
         standby_out <= 1'b1;
         wait_busy <= 1'b0;
         req_tgl <= 1'b0;
         bs1 <= 1'b0;
         bs2 <= 1'b0;
      end
      else
      begin
         st <= next_st;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         txb <= next_txb;
         seg <= next_seg;
         addr <= next_addr;
         pbuf <= next_pbuf;
         pval <= next_pval;
         pbase <= next_pbase;
         rw <= next_rw;
         mnak <= next_mnak;
         sda_oe_out <= next_oe;
         sda_out <= 1'b0; // RL19
         standby_out <= (next_st == ees_pkg::ST_IDLE); // RL4
         wait_busy <= next_wait;
         req_tgl <= next_tgl;
         bs1 <= prog_busy_out;
         bs2 <= bs1;
      end
   end

   always_ff @(posedge clk_link_in)
   begin
      if (commit)
         for (int i = 0; i < `EES_PAGE_BYTES; i++)
            if (pval[i])
               mem[{pbase, 4'(i)}] <= pbuf[i]; // RL14
   end

   // ------------------------------------------------------------
   // Program cycle timer
   // ------------------------------------------------------------
   logic [2:0] rq;
   logic [PROG_W-1:0] pcnt;
   logic [PROG_W-1:0] next_pcnt;
   logic next_busy;

   always_comb
   begin
      next_pcnt = pcnt;
      next_busy = prog_busy_out;
      if (rq[2] ^ rq[1])
      begin
         next_busy = 1'b1; // RL8
         next_pcnt = PROG_W'(PROG_CYCLES - 1);
      end
      else if (prog_busy_out)
      begin
         if (pcnt == '0)
            next_busy = 1'b0;
         else
            next_pcnt = pcnt - PROG_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rq <= 3'h0;
         pcnt <= '0;
         prog_busy_out <= 1'b0;
      end
      else
      begin
         rq <= {rq[1:0], req_tgl};
         pcnt <= next_pcnt;
         prog_busy_out <= next_busy;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_busy_hold;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      $rose(prog_busy_out) |-> prog_busy_out [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) // RL8
      else $error("program cycle ended too early");

   property p_busy_quiet;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      (link_busy && st == ees_pkg::ST_IDLE) |=> !sda_oe_out;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) // RL9
      else $error("SDA pulled while programming");

   property p_drive_on_fall;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      $rose(sda_oe_out) |-> $past(fall) && !filt.scl;
   endproperty
   a_drive_on_fall: assert property (p_drive_on_fall) // RL5
      else $error("SDA pulled outside SCL low");

   property p_low_only;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      sda_oe_out |-> sda_out == 1'b0;
   endproperty
   a_low_only: assert property (p_low_only) // RL19
      else $error("SDA driven high");

   property p_stop_standby;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      stop |=> standby_out && !sda_oe_out;
   endproperty
   a_stop_standby: assert property (p_stop_standby) // RL4
      else $error("no standby after stop");

   property p_start_addr;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      (start && !stop && !link_busy) |=> st == ees_pkg::ST_DEV
         && bitcnt == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr) // RL1
      else $error("start not taken");

   property p_idle_silent;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      (st == ees_pkg::ST_IDLE && !start) |=> st == ees_pkg::ST_IDLE
         && !sda_oe_out;
   endproperty
   a_idle_silent: assert property (p_idle_silent) // RL2
      else $error("activity taken without start");

   property p_wp_nack;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      (fall && !stop && !start && st == ees_pkg::ST_DATA &&
         bitcnt == `EES_BYTE_BITS && wp_s && addr[10])
         |=> !sda_oe_out && st == ees_pkg::ST_SKIP && pval == '0;
   endproperty
   a_wp_nack: assert property (p_wp_nack) // RL12
      else $error("protected byte acknowledged");

   property p_page_wrap;
      @(posedge clk_link_in) disable iff (!rst_n_link)
      (fall && !stop && !start && st == ees_pkg::ST_DATA &&
         bitcnt == `EES_BYTE_BITS && !(wp_s && addr[10]))
         |=> addr[3:0] == $past(addr[3:0]) + 4'h1
         && addr[10:4] == $past(addr[10:4]) && sda_oe_out;
   endproperty
   a_page_wrap: assert property (p_page_wrap) // RL24
      else $error("page address did not wrap");
endmodule

// File: ees_master.sv
// Purpose: Two-wire bus master model
// Assumes: Open-drain SDA with pull-up resolved in the bench; SCL driven directly
// Notes: Steps on falling clock edges; glitches only on request
`timescale 1ns/1ps
module ees_master (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   // ----------------
   // Idle lines
   // ----------------
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end

   // ----------------
   // Bus steps
   // ----------------
   task automatic q();
      repeat (6) @(negedge clk_in);
   endtask

   task automatic start();
      sda_out = 1'b1;
      q();
      scl_out = 1'b1;
      q();
      sda_out = 1'b0;
      q();
      scl_out = 1'b0;
   endtask

   task automatic stop();
      scl_out = 1'b0;
      q();
      sda_out = 1'b0;
      q();
      scl_out = 1'b1;
      q();
      sda_out = 1'b1;
      q();
   endtask

   task automatic bit_io(input logic b, input int g, output logic r);
      scl_out = 1'b0;
      q();
      sda_out = b;
      q();
      scl_out = 1'b1;
      q();
      r = sda_in;
      if (g > 0)
      begin
         scl_out = 1'b0;
         #(g);
         scl_out = 1'b1;
      end
      q();
      scl_out = 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] d, input logic m_ack,
      input int g, output logic [7:0] rd, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], (i == 7) ? g : 0, r);
         rd[i] = r;
      end
      bit_io(~m_ack, 0, r);
      ack = ~r;
   endtask
endmodule

// File: ees_frontend_test.sv
// Purpose: Self-checking bench for the serial memory front end
// Assumes: Master model drives the bus; pull-up on SDA
// Notes: Program time shortened through PROG_CYCLES
`timescale 1ns/1ps
module ees_frontend_test;
   localparam int PROG = 600;
   logic clk_sys_in;
   logic clk_link_in;
   logic rst_n_in;
   logic wp_in;
   logic fast_mode_in;
   logic m_scl;
   logic m_sda;
   logic sda_w;
   logic sda_out;
   logic sda_oe_out;
   logic standby_out;
   logic prog_busy_out;
   logic [7:0] got [0:15];
   int num_errors = 0;
   int checks = 0;

   // ----------------
   // Bus and blocks
   // ----------------
   assign sda_w = m_sda & (sda_oe_out ? sda_out : 1'b1);

   ees_frontend #(.PROG_CYCLES(PROG)) DUT (
      .clk_sys_in(clk_sys_in),
      .clk_link_in(clk_link_in),
      .rst_n_in(rst_n_in),
      .scl_in(m_scl),
      .sda_in(sda_w),
      .wp_in(wp_in),
      .fast_mode_in(fast_mode_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .standby_out(standby_out),
      .prog_busy_out(prog_busy_out)
   );

   ees_master mst (
      .clk_in(clk_sys_in),
      .sda_in(sda_w),
      .scl_out(m_scl),
      .sda_out(m_sda)
   );

   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   initial
   begin
      clk_link_in = 1'b0;
      #3.7;
      forever #6 clk_link_in = ~clk_link_in;
   end

   // ----------------
   // Helpers
   // ----------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tx(input logic [7:0] d, output logic ack);
      logic [7:0] x;
      mst.byte_io(d, 1'b0, 0, x, ack);
   endtask

   task automatic wr(input logic [2:0] seg, input logic [7:0] word,
      input int n, input logic [7:0] d0, input logic last);
      logic ack;
      mst.start();
      tx({4'ha, seg, 1'b0}, ack);
      chk(ack, 1'b1);
      tx(word, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         tx(d0 + 8'(i), ack);
         chk(ack, last);
      end
      mst.stop();
   endtask

   task automatic rdn(input logic [2:0] seg, input logic [7:0] word,
      input int n);
      logic ack;
      logic [7:0] x;
      mst.start();
      tx({4'ha, seg, 1'b0}, ack);
      tx(word, ack);
      mst.start();
      tx({4'ha, seg, 1'b1}, ack);
      chk(ack, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         mst.byte_io(8'hff, i < n - 1, 0, x, ack);
         got[i] = x;
      end
      mst.stop();
      chk(standby_out, 1'b1);
   endtask

   task automatic settle(input logic prog);
      logic saw;
      int n;
      saw = 1'b0;
      n = 0;
      while (n < 40 && !(saw && prog))
      begin
         saw = saw | prog_busy_out;
         @(negedge clk_sys_in);
         n++;
      end
      chk(saw, prog);
      if (saw !== prog)
         close_out();
      n = 0;
      while (prog_busy_out !== 1'b0 && n < PROG + 100)
      begin
         @(negedge clk_sys_in);
         n++;
      end
      if (n == PROG + 100)
      begin
         chk(prog_busy_out, 1'b0);
         close_out();
      end
      repeat (10) @(negedge clk_sys_in);
   endtask

   // ----------------
   // Scenarios
   // ----------------
   task automatic t_nostart();
      logic ack;
      tx(8'ha0, ack);
      chk(ack, 1'b0);
      mst.stop();
      $display("no start: done");
   endtask

   task automatic t_type();
      logic ack;
      mst.start();
      tx(8'h92, ack);
      chk(ack, 1'b0);
      mst.stop();
      $display("wrong type: done");
   endtask

   task automatic t_byte();
      logic ack;
      wr(3'h5, 8'h10, 1, 8'h3c, 1'b1);
      mst.start();
      tx(8'ha0, ack);
      chk(ack, 1'b0);
      mst.stop();
      settle(1'b1);
      rdn(3'h5, 8'h10, 1);
      chk(got[0], 8'h3c);
      $display("byte write: done");
   endtask

   task automatic t_page();
      wr(3'h2, 8'h40, 18, 8'h80, 1'b1);
      settle(1'b1);
      rdn(3'h2, 8'h40, 16);
      for (int i = 0; i < 16; i++)
         chk(got[i], 8'h80 + 8'(i < 2 ? i + 16 : i));
      $display("page wrap: done");
   endtask

   task automatic t_protect();
      wp_in = 1'b1;
      wr(3'h5, 8'h10, 1, 8'hc3, 1'b0);
      settle(1'b0);
      rdn(3'h5, 8'h10, 1);
      chk(got[0], 8'h3c);
      wr(3'h1, 8'h10, 1, 8'h5a, 1'b1);
      settle(1'b1);
      rdn(3'h1, 8'h10, 1);
      chk(got[0], 8'h5a);
      rdn(3'h5, 8'h10, 1);
      chk(got[0], 8'h3c);
      wp_in = 1'b0;
      $display("protect: done");
   endtask

   task automatic t_glitch();
      logic ack;
      logic [7:0] x;
      for (int m = 0; m < 2; m++)
      begin
         fast_mode_in = m[0];
         mst.start();
         mst.byte_io(8'ha0, 1'b0, m ? 40 : 80, x, ack);
         chk(ack, 1'b1);
         mst.stop();
      end
      fast_mode_in = 1'b0;
      $display("glitch: done");
   endtask

   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      rst_n_in = 1'b0;
      wp_in = 1'b0;
      fast_mode_in = 1'b0;
      repeat (4) @(negedge clk_sys_in);
      chk(sda_oe_out, 1'b0);
      chk(standby_out, 1'b1);
      chk(prog_busy_out, 1'b0);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      $display("reset: done");
      t_nostart();
      t_type();
      t_byte();
      t_page();
      t_protect();
      t_glitch();
      close_out();
   end
endmodule
